// ==== design/ubg_divider.v ====
// one stage of the divide chain: emits one tick per limit+1 input ticks
`timescale 1ns/1ps
module ubg_divider #(
   parameter W = 8
) (
   input  wire         aclk,
   input  wire         aresetn,
   input  wire         clear,
   input  wire         tick_in,
   input  wire [W-1:0] limit,
   output reg          tick_q
);
   reg [W-1:0] cnt_q;

   // >= rather than == so a lowered limit never makes the count wrap through 2^W
   always @(posedge aclk) begin
      if (!aresetn || clear) begin
         cnt_q  <= {W{1'b0}};
         tick_q <= 1'b0;
      end else begin
         tick_q <= 1'b0;
         if (tick_in) begin
            if (cnt_q >= limit) begin
               cnt_q  <= {W{1'b0}};
               tick_q <= 1'b1;
            end else begin
               cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
            end
         end
      end
   end
endmodule // ubg_divider

// ==== design/ubg_regs.vh ====
// register offsets, field positions, reset values and divide limits of the baud generator
`ifndef UBG_REGS_VH
`define UBG_REGS_VH

`define UBG_ADDR_W          8
`define UBG_OFF_MODE        8'h00
`define UBG_OFF_DIVISOR     8'h04
`define UBG_OFF_CONTROL     8'h08
`define UBG_OFF_STATUS      8'h0C

`define UBG_MODE_RESET      8'h00
`define UBG_DIVISOR_RESET   8'h00
`define UBG_CONTROL_RESET   8'h00

`define UBG_MODE_CLK_SEL    0
`define UBG_MODE_PS_LOW     1
`define UBG_MODE_PS_HIGH    2

`define UBG_CTL_TX_EN       0
`define UBG_CTL_RX_EN       1
`define UBG_CTL_TX_INIT     2
`define UBG_CTL_RX_INIT     3

`define UBG_STS_ACTIVE      0
`define UBG_STS_RX_SAMPLE   1
`define UBG_STS_CLK_SEL     2

`define UBG_PS_DIV1         2'h0
`define UBG_PS_DIV8         2'h1
`define UBG_PS_DIV32        2'h2
`define UBG_PS_DIV256       2'h3

`define UBG_PRE_LIM_DIV1    8'h00
`define UBG_PRE_LIM_DIV8    8'h07
`define UBG_PRE_LIM_DIV32   8'h1F
`define UBG_PRE_LIM_DIV256  8'hFF

`define UBG_OVERSAMPLE_LIM  4'hF

`define UBG_RESP_OKAY       2'h0
`define UBG_RESP_SLVERR     2'h2

`endif

// ==== design/ubg_top.v ====
// baud rate generator with its mode, divisor and control registers on an AXI4-Lite slave
// Functional notes
// - bit rate is prescaled clock over sixteen times divisor plus one.
// - mode bit 0 picks system clock or special count clock as source.
// - prescaler divides the chosen source by 1, 8, 32 or 256.
// - every divisor value 0 to 255 is accepted and used.
// - divisor applies continuously while enabled or a transfer is busy.
// - control register is readable and writable.
// - basic clock runs at sixteen times bit rate and samples receive input.
// - control bits 0 and 1 are transmit enable and receive enable.
`timescale 1ns/1ps
`include "ubg_regs.vh"
module ubg_top #(
   parameter DIV_W = 8
) (
   input  wire                   aclk,
   input  wire                   aresetn,
   input  wire [`UBG_ADDR_W-1:0] s_axi_awaddr,
   input  wire                   s_axi_awvalid,
   output reg                    s_axi_awready,
   input  wire [31:0]            s_axi_wdata,
   input  wire [3:0]             s_axi_wstrb,
   input  wire                   s_axi_wvalid,
   output reg                    s_axi_wready,
   output reg  [1:0]             s_axi_bresp,
   output reg                    s_axi_bvalid,
   input  wire                   s_axi_bready,
   input  wire [`UBG_ADDR_W-1:0] s_axi_araddr,
   input  wire                   s_axi_arvalid,
   output reg                    s_axi_arready,
   output reg  [31:0]            s_axi_rdata,
   output reg  [1:0]             s_axi_rresp,
   output reg                    s_axi_rvalid,
   input  wire                   s_axi_rready,
   input  wire                   special_count_clock,
   input  wire                   transfer_busy,
   input  wire                   rx_data_in,
   output wire                   basic_clk_tick,
   output wire                   bit_tick,
   output reg                    rx_sample_q,
   output reg                    tx_enable_q,
   output reg                    rx_enable_q,
   output reg                    tx_init_q,
   output reg                    rx_init_q
);
   reg  [7:0]             uart_mode_reg_q;
   reg  [DIV_W-1:0]       baud_divisor_reg_q;
   reg  [7:0]             uart_control_reg_q;
   reg                    aw_held_q;
   reg                    w_held_q;
   reg  [`UBG_ADDR_W-1:0] aw_addr_q;
   reg  [31:0]            w_data_q;
   reg  [3:0]             w_strb_q;
   reg                    scc_prev_q;
   reg  [7:0]             pre_limit;
   reg  [31:0]            rd_data;
   reg                    rd_hit;
   reg                    wr_hit;
   wire                   src_tick;
   wire                   pre_tick;
   wire                   gen_active;
   wire                   aw_take;
   wire                   w_take;
   wire                   wr_go;
   wire [`UBG_ADDR_W-1:0] wr_addr;
   wire [31:0]            wr_data;
   wire                   wr_lane0;
   wire                   prescale_select_low;
   wire                   prescale_select_high;

   assign prescale_select_low  = uart_mode_reg_q[`UBG_MODE_PS_LOW];
   assign prescale_select_high = uart_mode_reg_q[`UBG_MODE_PS_HIGH];

   // ---------------- AXI4-Lite write path ----------------
   assign aw_take  = s_axi_awvalid && s_axi_awready;
   assign w_take   = s_axi_wvalid && s_axi_wready;
   assign wr_go    = (aw_held_q || aw_take) && (w_held_q || w_take) && !s_axi_bvalid;
   assign wr_addr  = aw_held_q ? aw_addr_q : s_axi_awaddr;
   assign wr_data  = w_held_q ? w_data_q : s_axi_wdata;
   assign wr_lane0 = w_held_q ? w_strb_q[0] : s_axi_wstrb[0];

   always @* begin
      case ({wr_addr[`UBG_ADDR_W-1:2], 2'b00})
         `UBG_OFF_MODE,
         `UBG_OFF_DIVISOR,
         `UBG_OFF_CONTROL: wr_hit = 1'b1;
         default:          wr_hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `UBG_RESP_OKAY;
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         aw_addr_q     <= {`UBG_ADDR_W{1'b0}};
         w_data_q      <= 32'h00000000;
         w_strb_q      <= 4'h0;
      end else begin
         if (aw_take && !wr_go) begin
            aw_held_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (w_take && !wr_go) begin
            w_held_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `UBG_RESP_OKAY : `UBG_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // one write at a time: readies drop once a half is held or a response waits
         s_axi_awready <= !(aw_held_q || aw_take || wr_go) && !s_axi_bvalid;
         s_axi_wready  <= !(w_held_q || w_take || wr_go) && !s_axi_bvalid;
         if (wr_go || s_axi_bvalid) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
         end
      end
   end

   // ---------------- registers ----------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         uart_mode_reg_q    <= `UBG_MODE_RESET;
         baud_divisor_reg_q <= `UBG_DIVISOR_RESET;
         uart_control_reg_q <= `UBG_CONTROL_RESET;
      end else if (wr_go && wr_lane0) begin
         case ({wr_addr[`UBG_ADDR_W-1:2], 2'b00})
            `UBG_OFF_MODE:    uart_mode_reg_q    <= wr_data[7:0];
            `UBG_OFF_DIVISOR: baud_divisor_reg_q <= wr_data[DIV_W-1:0];
            `UBG_OFF_CONTROL: uart_control_reg_q <= wr_data[7:0];
            default:          uart_mode_reg_q    <= uart_mode_reg_q;
         endcase
      end
   end

   // ---------------- AXI4-Lite read path ----------------
   always @* begin
      rd_hit  = 1'b1;
      rd_data = 32'h00000000;
      case ({s_axi_araddr[`UBG_ADDR_W-1:2], 2'b00})
         `UBG_OFF_MODE:    rd_data[7:0]       = uart_mode_reg_q;
         `UBG_OFF_DIVISOR: rd_data[DIV_W-1:0] = baud_divisor_reg_q;
         `UBG_OFF_CONTROL: rd_data[7:0]       = uart_control_reg_q;
         `UBG_OFF_STATUS: begin
            rd_data[`UBG_STS_ACTIVE]    = gen_active;
            rd_data[`UBG_STS_RX_SAMPLE] = rx_sample_q;
            rd_data[`UBG_STS_CLK_SEL]   = uart_mode_reg_q[`UBG_MODE_CLK_SEL];
         end
         default:          rd_hit = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `UBG_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_data;
            s_axi_rresp   <= rd_hit ? `UBG_RESP_OKAY : `UBG_RESP_SLVERR;
         end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
               s_axi_rvalid <= 1'b0;
            end
            s_axi_arready <= 1'b0;
         end else begin
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ---------------- baud chain ----------------
   // enables and init bits are registered copies of the control register bits, one cycle behind
   always @(posedge aclk) begin
      if (!aresetn) begin
         tx_enable_q <= 1'b0;
         rx_enable_q <= 1'b0;
         tx_init_q   <= 1'b0;
         rx_init_q   <= 1'b0;
         scc_prev_q  <= 1'b0;
         rx_sample_q <= 1'b1;
      end else begin
         tx_enable_q <= uart_control_reg_q[`UBG_CTL_TX_EN];
         rx_enable_q <= uart_control_reg_q[`UBG_CTL_RX_EN];
         tx_init_q   <= uart_control_reg_q[`UBG_CTL_TX_INIT];
         rx_init_q   <= uart_control_reg_q[`UBG_CTL_RX_INIT];
         scc_prev_q  <= special_count_clock;
         if (basic_clk_tick) begin
            rx_sample_q <= rx_data_in;
         end
      end
   end

   // idle chain is held cleared, so a divisor changed while idle restarts from a clean phase
   assign gen_active = tx_enable_q || rx_enable_q || transfer_busy;

   // one source tick per system clock, or per rising edge of the special count clock
   assign src_tick = uart_mode_reg_q[`UBG_MODE_CLK_SEL] ?
                     (special_count_clock && !scc_prev_q) : 1'b1;

   always @* begin
      case ({prescale_select_high, prescale_select_low})
         `UBG_PS_DIV1:   pre_limit = `UBG_PRE_LIM_DIV1;
         `UBG_PS_DIV8:   pre_limit = `UBG_PRE_LIM_DIV8;
         `UBG_PS_DIV32:  pre_limit = `UBG_PRE_LIM_DIV32;
         `UBG_PS_DIV256: pre_limit = `UBG_PRE_LIM_DIV256;
         default:        pre_limit = `UBG_PRE_LIM_DIV1;
      endcase
   end

   ubg_divider #(.W(8)) u_prescale (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (!gen_active),
      .tick_in (src_tick),
      .limit   (pre_limit),
      .tick_q  (pre_tick)
   );

   ubg_divider #(.W(DIV_W)) u_divisor (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (!gen_active),
      .tick_in (pre_tick),
      .limit   (baud_divisor_reg_q),
      .tick_q  (basic_clk_tick)
   );

   ubg_divider #(.W(4)) u_oversample (
      .aclk    (aclk),
      .aresetn (aresetn),
      .clear   (!gen_active),
      .tick_in (basic_clk_tick),
      .limit   (`UBG_OVERSAMPLE_LIM),
      .tick_q  (bit_tick)
   );
endmodule // ubg_top

// ==== verification/ubg_props.sv ====
// assertion checker for the baud generator ports
`timescale 1ns/1ps
module ubg_props (
   input wire       aclk,
   input wire       aresetn,
   input wire       s_axi_awvalid,
   input wire       s_axi_awready,
   input wire       s_axi_wvalid,
   input wire       s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire       s_axi_bvalid,
   input wire       s_axi_bready,
   input wire       s_axi_arvalid,
   input wire       s_axi_arready,
   input wire       s_axi_rvalid,
   input wire       s_axi_rready,
   input wire       transfer_busy,
   input wire       rx_data_in,
   input wire       basic_clk_tick,
   input wire       bit_tick,
   input wire       rx_sample_q,
   input wire       tx_enable_q,
   input wire       rx_enable_q
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // four idle cycles cover the two-flop tick pipeline
   a_idle_quiet: assert property ((!tx_enable_q && !rx_enable_q && !transfer_busy) [*4] |-> !basic_clk_tick)
      else $error("tick while idle");
   a_rx_capture: assert property (basic_clk_tick |=> rx_sample_q == $past(rx_data_in)) else $error("bad sample");
   a_rx_hold: assert property (!basic_clk_tick |=> $stable(rx_sample_q)) else $error("sample moved");
   a_bit_spacing: assert property (bit_tick |=> !bit_tick [*8]) else $error("bit ticks too close");
   a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
      else $error("no write answer");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("read answer dropped");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
endmodule // ubg_props

// ==== verification/ubg_remote.sv ====
// remote serial device sending one framed byte on the receive line
`timescale 1ns/1ps
module ubg_remote (
   input  wire       aclk,
   input  wire       bit_tick,
   input  wire       send,
   input  wire [7:0] data,
   output wire       line
);
   // idle line rests at mark, as a pulled-up line would
   reg [9:0] frame_q = 10'h3FF;
   always @(posedge aclk) begin
      if (send)
         frame_q <= {1'h1, data, 1'h0};
      else if (bit_tick)
         frame_q <= {1'h1, frame_q[9:1]};
   end
   assign line = frame_q[0];
endmodule // ubg_remote

// ==== verification/ubg_top_tb.sv ====
// self-checking bench for the baud generator
`timescale 1ns/1ps
module ubg_top_tb;
   reg         aclk = 1'h0, aresetn = 1'h0, transfer_busy = 1'h0, send = 1'h0;
   reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg  [31:0] s_axi_wdata = 32'h0, rd;
   reg  [3:0]  s_axi_wstrb = 4'hF;
   reg         s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   reg         s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ka, kb;
   reg  [2:0]  sc_q = 3'h0;
   reg  [1:0]  rs;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire        rx_data_in, basic_clk_tick, bit_tick, rx_sample_q, tx_enable_q, rx_enable_q, tx_init_q, rx_init_q;
   // special source rises once every six aclk cycles
   wire        special_count_clock = (sc_q < 3'h3);
   integer     n_mismatch = 0, samples_checked = 0, i, j, c;
   always #25 aclk = ~aclk;
   always @(posedge aclk) sc_q <= (sc_q == 3'h5) ? 3'h0 : sc_q + 3'h1;
   ubg_top dut (.*);
   ubg_remote peer (.aclk(aclk), .bit_tick(bit_tick), .send(send), .data(8'hA5), .line(rx_data_in));
   task final_report;
      begin
         $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
         if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task tmo;
      begin
         n_mismatch = n_mismatch + 1;
         final_report;
      end
   endtask
   task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   // sampling at the falling edge keeps the handshake free of races
   task wr(input [7:0] a, input [31:0] d, input [1:0] er);
      begin
         kb = 1'h0;
         {s_axi_awaddr, s_axi_wdata} <= {a, d};
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
         for (i = 0; i < 50 && !kb; i = i + 1) begin
            @(negedge aclk);
            {ka, c[0], kb, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
            @(posedge aclk);
            if (ka) s_axi_awvalid <= 1'h0;
            if (c[0]) s_axi_wvalid <= 1'h0;
         end
         s_axi_bready <= 1'h0;
         if (!kb) tmo;
         chk("bresp", er, rs);
         @(posedge aclk);
      end
   endtask
   task rdc(input [7:0] a, input [31:0] ed, input [1:0] er);
      begin
         kb = 1'h0;
         s_axi_araddr <= a;
         {s_axi_arvalid, s_axi_rready} <= 2'h3;
         for (i = 0; i < 50 && !kb; i = i + 1) begin
            @(negedge aclk);
            {ka, kb, rd, rs} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (ka) s_axi_arvalid <= 1'h0;
         end
         s_axi_rready <= 1'h0;
         if (!kb) tmo;
         chk("rdata", ed, rd);
         chk("rresp", er, rs);
         @(posedge aclk);
      end
   endtask
   task gap(input s);
      begin
         c = 0;
         do begin
            @(negedge aclk);
            c = c + 1;
         end while (c < 9000 && (s ? bit_tick : basic_clk_tick) !== 1'h1);
         if (c >= 9000) tmo;
      end
   endtask
   // first interval after a change may be partial, so the third one counts
   task per(input s, input integer e);
      begin
         gap(s);
         gap(s);
         gap(s);
         chk("period", e, c);
         @(posedge aclk);
      end
   endtask
   task ctl(input [31:0] d, input [3:0] e);
      begin
         wr(8'h08, d, 2'h0);
         @(negedge aclk);
         chk("ctlbits", e, {rx_init_q, tx_init_q, rx_enable_q, tx_enable_q});
         @(posedge aclk);
      end
   endtask
   task t_regs;
      begin
         rdc(8'h00, 32'h0, 2'h0);
         rdc(8'h08, 32'h0, 2'h0);
         wr(8'h04, 32'hA5, 2'h0);
         rdc(8'h04, 32'hA5, 2'h0);
         ctl(32'hFFFFFFF9, 4'h9);
         rdc(8'h08, 32'hF9, 2'h0);
         ctl(32'h6, 4'h6);
         rdc(8'h0C, 32'h3, 2'h0);
         wr(8'h10, 32'h1, 2'h2);
         rdc(8'h10, 32'h0, 2'h2);
         $display("regs done");
      end
   endtask
   task t_rates;
      for (j = 0; j < 5; j = j + 1) begin
         wr(8'h08, 32'h0, 2'h0);
         wr(8'h00, (j % 4) * 2, 2'h0);
         wr(8'h04, (j == 4) ? 255 : j % 3, 2'h0);
         wr(8'h08, 32'h1, 2'h0);
         // prescale factors 1, 8, 32, 256 are 2 to the 0, 3, 5, 8
         per(1'h0, (1 << ((j % 4) * 3 - ((j % 4) > 1 ? 1 : 0))) * ((j == 4) ? 256 : j % 3 + 1));
         $display("rate %0d done", j);
      end
   endtask
   task t_other;
      begin
         wr(8'h08, 32'h0, 2'h0);
         wr(8'h00, 32'h1, 2'h0);
         wr(8'h04, 32'h1, 2'h0);
         wr(8'h08, 32'h1, 2'h0);
         per(1'h0, 12);
         // idle receive line keeps the sample bit at mark
         rdc(8'h0C, 32'h7, 2'h0);
         wr(8'h08, 32'h0, 2'h0);
         wr(8'h00, 32'h0, 2'h0);
         wr(8'h04, 32'h0, 2'h0);
         c = 0;
         repeat (300) begin
            @(negedge aclk);
            if (basic_clk_tick !== 1'h0) c = c + 1;
         end
         chk("idle", 0, c);
         @(posedge aclk);
         transfer_busy <= 1'h1;
         per(1'h0, 1);
         transfer_busy <= 1'h0;
         $display("source and idle done");
      end
   endtask
   task t_rx;
      begin
         wr(8'h08, 32'h2, 2'h0);
         gap(1'h1);
         @(posedge aclk);
         send <= 1'h1;
         @(posedge aclk);
         send <= 1'h0;
         for (j = 0; j < 10; j = j + 1) begin
            repeat (8) @(negedge aclk);
            chk("rxbit", (10'h34A >> j) & 1, rx_sample_q);
            repeat (8) @(negedge aclk);
         end
         @(posedge aclk);
         per(1'h1, 16);
         $display("receive done");
      end
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      @(posedge aclk);
      t_regs;
      t_rates;
      t_other;
      t_rx;
      final_report;
   end
endmodule // ubg_top_tb
bind ubg_top ubg_props u_props (.*);
